// ### hdl/boot_image_loader.sv
module boot_image_loader #(
  parameter int ADDR_W = 15,
  parameter int GPIO_N = 32
) (
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  input  wire logic                  rst_n_i,
  output logic [GPIO_N-1:0]          gpio_pulldown_o,
  output logic                       core_reset_o,
  output logic [31:0]                start_addr_o,
  output logic                       boot_done_o,
  output logic                       boot_error_o,
  output logic                       flash_sclk_o,
  output logic                       flash_cs_n_o,
  output logic                       flash_mosi_o,
  input  wire logic                  flash_miso_i,
  output logic                       otp_rd_o,
  output logic [boot_loader_pkg::OTP_ADDR_W-1:0] otp_addr_o,
  input  wire logic [31:0]           otp_data_i,
  input  wire logic                  otp_valid_i,
  output logic                       ram_we_o,
  output logic [ADDR_W-1:0]          ram_addr_o,
  output logic [31:0]                ram_wdata_o
);

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_INTRST,
    ST_SEC_RD,
    ST_LOAD,
    ST_DONE,
    ST_ERR
  } boot_state_t;

  boot_state_t                  state_reg;
  boot_loader_pkg::load_phase_t phase_reg;
  logic        rst_meta_reg, rst_sync_reg;
  logic        miso_meta_reg, miso_sync_reg;
  logic [11:0] wait_cnt_reg;
  logic        from_otp_reg;
  logic        otp_busy_reg;
  logic [boot_loader_pkg::OTP_ADDR_W-1:0] otp_addr_reg;
  logic [31:0] otp_word_reg;
  logic [2:0]  otp_left_reg;
  logic [1:0]  div_cnt_reg;
  logic        sclk_reg, cs_n_reg;
  logic [31:0] tx_reg;
  logic [5:0]  bit_cnt_reg;
  logic [7:0]  rx_reg;
  logic [2:0]  rx_cnt_reg;
  logic        byte_valid;
  logic [7:0]  byte_data;
  logic        flash_byte_reg;
  logic [7:0]  flash_data_reg;
  logic [31:0] shift_reg, shift_next;
  logic [1:0]  byte_idx_reg;
  logic [31:0] len_reg, word_cnt_reg;
  logic [31:0] crc_reg, crc_next;
  logic        core_reset_reg, done_reg, err_reg;
  logic        ram_we_reg;
  logic [ADDR_W-1:0] ram_addr_reg;
  logic [31:0] ram_wdata_reg;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rst_meta_reg  <= 1'b0;
      rst_sync_reg  <= 1'b0;
      miso_meta_reg <= 1'b0;
      miso_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg  <= rst_n_i;
      rst_sync_reg  <= rst_meta_reg;
      miso_meta_reg <= flash_miso_i;
      miso_sync_reg <= miso_meta_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Boot sequencer
  // ---------------------------------------------------------------------------
  wire logic word_end  = byte_valid && (byte_idx_reg == 2'h3);
  wire logic last_word = (word_cnt_reg + 32'h00000001) == len_reg;
  wire logic crc_ok    = (shift_next == boot_loader_pkg::CRC_SKIP) ||
                         (shift_next == ~crc_reg);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg      <= ST_HOLD;
      wait_cnt_reg   <= 12'h000;
      from_otp_reg   <= 1'b0;
      core_reset_reg <= 1'b1;
      done_reg       <= 1'b0;
      err_reg        <= 1'b0;
    end else if (!rst_sync_reg) begin
      state_reg      <= ST_HOLD;
      wait_cnt_reg   <= 12'h000;
      core_reset_reg <= 1'b1;
      done_reg       <= 1'b0;
      err_reg        <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_HOLD: state_reg <= ST_INTRST;
        ST_INTRST: begin
          wait_cnt_reg <= wait_cnt_reg + 12'h001;
          if (wait_cnt_reg == 12'(boot_loader_pkg::INTRST_CYCLES - 1)) begin
            state_reg <= ST_SEC_RD;
          end
        end
        ST_SEC_RD: begin
          if (otp_valid_i) begin
            from_otp_reg <= otp_data_i[boot_loader_pkg::SEC_BOOT_BIT];
            state_reg    <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (word_end && (phase_reg == boot_loader_pkg::PH_CRC)) begin
            if (crc_ok) begin
              state_reg      <= ST_DONE;
              core_reset_reg <= 1'b0;
              done_reg       <= 1'b1;
            end else begin
              state_reg <= ST_ERR;
              err_reg   <= 1'b1;
            end
          end
        end
        ST_DONE: state_reg <= ST_DONE;
        ST_ERR:  state_reg <= ST_ERR;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // OTP reads: security word first, then boot words upward from address 0
  // ---------------------------------------------------------------------------
  wire logic otp_load = (state_reg == ST_LOAD) && from_otp_reg;
  wire logic otp_req  = !otp_busy_reg && rst_sync_reg &&
                        ((state_reg == ST_SEC_RD) || (otp_load && otp_left_reg == 3'h0));

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      otp_busy_reg <= 1'b0;
      otp_addr_reg <= boot_loader_pkg::OTP_BOOT_ADDR;
      otp_word_reg <= 32'h00000000;
      otp_left_reg <= 3'h0;
    end else if (state_reg == ST_HOLD || state_reg == ST_INTRST) begin
      otp_busy_reg <= 1'b0;
      otp_addr_reg <= boot_loader_pkg::OTP_BOOT_ADDR;
      otp_left_reg <= 3'h0;
    end else begin
      if (otp_req) begin
        otp_busy_reg <= 1'b1;
      end else if (otp_valid_i) begin
        otp_busy_reg <= 1'b0;
      end
      if (otp_load && otp_valid_i) begin
        otp_word_reg <= otp_data_i;
        otp_left_reg <= 3'h4;
        otp_addr_reg <= otp_addr_reg + 11'h001;
      end else if (otp_left_reg != 3'h0) begin
        otp_word_reg <= {8'h00, otp_word_reg[31:8]};
        otp_left_reg <= otp_left_reg - 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Serial flash reader: mode 0, bits change on falling, sampled before it
  // ---------------------------------------------------------------------------
  wire logic flash_run = (state_reg == ST_LOAD) && !from_otp_reg && rst_sync_reg;
  wire logic div_tick  = div_cnt_reg == 2'(boot_loader_pkg::SCLK_HALF_CYCLES - 1);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_cnt_reg    <= 2'h0;
      sclk_reg       <= 1'b0;
      cs_n_reg       <= 1'b1;
      tx_reg         <= boot_loader_pkg::FLASH_READ_SEQ;
      bit_cnt_reg    <= 6'h00;
      rx_reg         <= 8'h00;
      rx_cnt_reg     <= 3'h0;
      flash_byte_reg <= 1'b0;
      flash_data_reg <= 8'h00;
    end else if (!flash_run) begin
      div_cnt_reg    <= 2'h0;
      sclk_reg       <= 1'b0;
      cs_n_reg       <= 1'b1;
      tx_reg         <= boot_loader_pkg::FLASH_READ_SEQ;
      bit_cnt_reg    <= 6'h00;
      rx_cnt_reg     <= 3'h0;
      flash_byte_reg <= 1'b0;
    end else begin
      cs_n_reg       <= 1'b0;
      flash_byte_reg <= 1'b0;
      div_cnt_reg    <= div_tick ? 2'h0 : div_cnt_reg + 2'h1;
      if (div_tick && !cs_n_reg) begin
        sclk_reg <= !sclk_reg;
        if (sclk_reg) begin
          // The synchronised input lags the pin by two cycles, which still lands
          // inside the high half period, so the sample precedes the flash's
          // next change after this falling edge.
          if (bit_cnt_reg != boot_loader_pkg::FLASH_HDR_BITS) begin
            tx_reg      <= {tx_reg[30:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
          end else begin
            rx_reg     <= {rx_reg[6:0], miso_sync_reg};
            rx_cnt_reg <= rx_cnt_reg + 3'h1;
            if (rx_cnt_reg == 3'h7) begin
              flash_byte_reg <= 1'b1;
              flash_data_reg <= {rx_reg[6:0], miso_sync_reg};
            end
          end
        end
      end
    end
  end

  assign byte_valid = from_otp_reg ? (otp_left_reg != 3'h0) : flash_byte_reg;
  assign byte_data  = from_otp_reg ? otp_word_reg[7:0] : flash_data_reg;

  // ---------------------------------------------------------------------------
  // Image parser, checksum and RAM writer
  // ---------------------------------------------------------------------------
  crc32_byte crc_step (
    .crc_i  (crc_reg),
    .data_i (byte_data),
    .crc_o  (crc_next)
  );

  assign shift_next = {byte_data, shift_reg[31:8]};

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_reg     <= boot_loader_pkg::PH_LEN;
      shift_reg     <= 32'h00000000;
      byte_idx_reg  <= 2'h0;
      len_reg       <= 32'h00000000;
      word_cnt_reg  <= 32'h00000000;
      crc_reg       <= boot_loader_pkg::CRC_INIT;
      ram_we_reg    <= 1'b0;
      ram_addr_reg  <= '0;
      ram_wdata_reg <= 32'h00000000;
    end else if (state_reg != ST_LOAD) begin
      phase_reg    <= boot_loader_pkg::PH_LEN;
      byte_idx_reg <= 2'h0;
      word_cnt_reg <= 32'h00000000;
      crc_reg      <= boot_loader_pkg::CRC_INIT;
      ram_we_reg   <= 1'b0;
    end else begin
      ram_we_reg <= 1'b0;
      if (byte_valid) begin
        shift_reg    <= shift_next;
        byte_idx_reg <= byte_idx_reg + 2'h1;
        if (phase_reg != boot_loader_pkg::PH_CRC) begin
          crc_reg <= crc_next;
        end
      end
      if (word_end) begin
        unique case (phase_reg)
          boot_loader_pkg::PH_LEN: begin
            len_reg   <= shift_next;
            phase_reg <= (shift_next == 32'h00000000) ? boot_loader_pkg::PH_CRC
                                                      : boot_loader_pkg::PH_PROG;
          end
          boot_loader_pkg::PH_PROG: begin
            ram_we_reg    <= 1'b1;
            ram_addr_reg  <= ADDR_W'(boot_loader_pkg::RAM_BASE + word_cnt_reg);
            ram_wdata_reg <= shift_next;
            word_cnt_reg  <= word_cnt_reg + 32'h00000001;
            if (last_word) begin
              phase_reg <= boot_loader_pkg::PH_CRC;
            end
          end
          boot_loader_pkg::PH_CRC: phase_reg <= boot_loader_pkg::PH_CRC;
          default: phase_reg <= boot_loader_pkg::PH_LEN;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign gpio_pulldown_o = (state_reg == ST_HOLD) ? '1 : '0;
  assign core_reset_o    = core_reset_reg;
  assign start_addr_o    = boot_loader_pkg::RAM_BASE;
  assign boot_done_o     = done_reg;
  assign boot_error_o    = err_reg;
  assign flash_sclk_o    = sclk_reg;
  assign flash_cs_n_o    = cs_n_reg;
  assign flash_mosi_o    = tx_reg[31];
  assign otp_rd_o        = otp_req;
  assign otp_addr_o      = (state_reg == ST_SEC_RD) ? boot_loader_pkg::OTP_SEC_ADDR
                                                    : otp_addr_reg;
  assign ram_we_o        = ram_we_reg;
  assign ram_addr_o      = ram_addr_reg;
  assign ram_wdata_o     = ram_wdata_reg;

endmodule : boot_image_loader

// ### hdl/crc32_byte.sv
module crc32_byte (
  input  wire logic [31:0] crc_i,
  input  wire logic [7:0]  data_i,
  output logic      [31:0] crc_o
);

  // Reflected form: the byte enters at the low end, least significant bit first.
  always_comb begin
    logic [31:0] c;
    c = crc_i ^ {24'h000000, data_i};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ boot_loader_pkg::CRC_POLY) : (c >> 1);
    end
    crc_o = c;
  end

endmodule : crc32_byte

// ### inc/boot_loader_pkg.sv
package boot_loader_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int INTRST_MIN_US = 15;
  localparam int INTRST_CYCLES = (INTRST_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYCLES = 4;

  // ---------------------------------------------------------------------------
  // Image format and checksum
  // ---------------------------------------------------------------------------
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_SKIP = 32'h0D15AB1E;
  localparam logic [31:0] RAM_BASE = 32'h00000000;

  // ---------------------------------------------------------------------------
  // Security word and boot sources
  // ---------------------------------------------------------------------------
  localparam int          SEC_BOOT_BIT  = 5;
  localparam int          OTP_ADDR_W    = 11;
  localparam logic [10:0] OTP_SEC_ADDR  = 11'h7FF;
  localparam logic [10:0] OTP_BOOT_ADDR = 11'h000;

  // ---------------------------------------------------------------------------
  // Serial flash read sequence: read command, then a 24-bit address of zero
  // ---------------------------------------------------------------------------
  localparam logic [31:0] FLASH_READ_SEQ = 32'h03000000;
  localparam logic [5:0]  FLASH_HDR_BITS = 6'h20;

  typedef enum logic [1:0] {
    PH_LEN,
    PH_PROG,
    PH_CRC
  } load_phase_t;

endpackage : boot_loader_pkg

// ### sim/boot_image_loader_monitor.sv
module boot_image_loader_monitor #(
  parameter int ADDR_W = 15,
  parameter int GPIO_N = 32
) (
  input wire logic                                  clk_i,
  input wire logic                                  reset_i,
  input wire logic                                  rst_n_i,
  input wire logic [GPIO_N-1:0]                     gpio_pulldown_o,
  input wire logic                                  core_reset_o,
  input wire logic [31:0]                           start_addr_o,
  input wire logic                                  boot_done_o,
  input wire logic                                  boot_error_o,
  input wire logic                                  flash_sclk_o,
  input wire logic                                  flash_cs_n_o,
  input wire logic                                  flash_mosi_o,
  input wire logic                                  flash_miso_i,
  input wire logic                                  otp_rd_o,
  input wire logic [boot_loader_pkg::OTP_ADDR_W-1:0] otp_addr_o,
  input wire logic [31:0]                           otp_data_i,
  input wire logic                                  otp_valid_i,
  input wire logic                                  ram_we_o,
  input wire logic [ADDR_W-1:0]                     ram_addr_o,
  input wire logic [31:0]                           ram_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [11:0]       hold_cnt;
  logic [ADDR_W-1:0] last_addr;
  logic              wr_seen;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // The count saturates so that a very late boot still reads as too late, not as early.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hold_cnt <= 12'h000;
    end else if (!rst_n_i) begin
      hold_cnt <= 12'h000;
    end else if (hold_cnt != 12'hFFF) begin
      hold_cnt <= hold_cnt + 12'h001;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_seen   <= 1'b0;
      last_addr <= '0;
    end else if (!rst_n_i) begin
      wr_seen   <= 1'b0;
      last_addr <= '0;
    end else if (ram_we_o) begin
      wr_seen   <= 1'b1;
      last_addr <= ram_addr_o;
    end
  end

  chk_hold_pulldown: assert property (!rst_n_i [*5] |-> gpio_pulldown_o == '1 && core_reset_o)
    else $error("pull-downs or core reset missing while the reset pin is low");
  chk_hold_quiet: assert property (!rst_n_i [*5] |-> !otp_rd_o && flash_cs_n_o && !ram_we_o)
    else $error("boot activity while the reset pin is low");
  chk_pulldown_free: assert property (rst_n_i [*8] |-> gpio_pulldown_o == '0)
    else $error("pull-downs still on after reset release");
  chk_intrst_wait: assert property (otp_rd_o && otp_addr_o == boot_loader_pkg::OTP_SEC_ADDR |->
    hold_cnt >= 12'(boot_loader_pkg::INTRST_CYCLES) && hold_cnt <= 12'hEA6)
    else $error("security word read outside the internal reset window");
  chk_ram_base: assert property (ram_we_o && !wr_seen |-> ram_addr_o == '0)
    else $error("first program word not at the lowest address");
  chk_ram_order: assert property (ram_we_o && wr_seen |-> ram_addr_o == last_addr + 1'b1)
    else $error("program word address not consecutive");
  chk_word_pack: assert property (ram_we_o |=> !ram_we_o [*3])
    else $error("RAM words written closer than four bytes apart");
  chk_done_start: assert property ($rose(boot_done_o) |-> start_addr_o == 32'h0 && !core_reset_o)
    else $error("start without zero address or with core still in reset");
  chk_error_hold: assert property (boot_error_o |-> core_reset_o && !boot_done_o)
    else $error("bad image allowed to run");
  chk_flash_release: assert property ($rose(boot_done_o || boot_error_o) |-> ##[0:2] flash_cs_n_o)
    else $error("flash still selected after the image ended");

  cov_done: cover property ($rose(boot_done_o));
  cov_error: cover property ($rose(boot_error_o));
  cov_otp_boot: cover property (otp_rd_o && otp_addr_o == boot_loader_pkg::OTP_BOOT_ADDR);
endmodule : boot_image_loader_monitor

// ### sim/boot_media_model.sv
module boot_media_model (
  input  wire logic        clk_i,
  input  wire logic        flash_sclk_i,
  input  wire logic        flash_cs_n_i,
  input  wire logic        flash_mosi_i,
  output logic             flash_miso_o,
  input  wire logic        otp_rd_i,
  input  wire logic [10:0] otp_addr_i,
  output logic [31:0]      otp_data_o,
  output logic             otp_valid_o,
  input  wire logic [3:0]  otp_lat_i
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0]  fmem [0:255];
  logic [31:0] omem [0:2047];
  logic [31:0] hdr;
  int          nbit;
  logic        drv;
  logic        pend;
  logic [3:0]  wait_cnt;
  logic [10:0] addr;

  initial begin
    drv = 1'b0;
    nbit = 0;
    pend = 1'b0;
    otp_valid_o = 1'b0;
    otp_data_o = 32'h00000000;
  end

  always @(negedge flash_cs_n_i) nbit = 0;
  always @(posedge flash_sclk_i) if (!flash_cs_n_i && nbit < 32) hdr = {hdr[30:0], flash_mosi_i};
  // Image bits leave msb first, one after each falling clock edge once the header is in.
  always @(negedge flash_sclk_i) begin
    if (!flash_cs_n_i) begin
      nbit = nbit + 1;
      if (nbit >= 32) drv = fmem[(nbit - 32) / 8][7 - (nbit - 32) % 8];
    end
  end
  // A line the flash is not driving shows the inverse of its last bit, so stale data never helps.
  assign flash_miso_o = (flash_cs_n_i || nbit < 32) ? ~drv : drv;

  always @(posedge clk_i) begin
    otp_valid_o <= 1'b0;
    otp_data_o  <= ~otp_data_o;
    if (otp_rd_i) begin
      pend     <= 1'b1;
      wait_cnt <= otp_lat_i;
      addr     <= otp_addr_i;
    end else if (pend && wait_cnt == 4'h1) begin
      pend        <= 1'b0;
      otp_valid_o <= 1'b1;
      otp_data_o  <= omem[addr];
    end else if (pend) begin
      wait_cnt <= wait_cnt - 4'h1;
    end
  end
endmodule : boot_media_model

// ### sim/test_boot_image_loader.sv
module test_boot_image_loader;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int ADDR_W = 15;
  localparam int GPIO_N = 32;

  logic              clk_i, reset_i, rst_n_i, flash_miso_i, otp_valid_i;
  logic              core_reset_o, boot_done_o, boot_error_o, otp_rd_o, ram_we_o;
  logic              flash_sclk_o, flash_cs_n_o, flash_mosi_o, cs_seen;
  logic [GPIO_N-1:0] gpio_pulldown_o;
  logic [31:0]       start_addr_o, otp_data_i, ram_wdata_o;
  logic [10:0]       otp_addr_o;
  logic [ADDR_W-1:0] ram_addr_o;
  logic [3:0]        otp_lat;
  logic [31:0]       wa [$];
  logic [31:0]       wd [$];
  int                n_errors, n_compared;

  boot_image_loader #(.ADDR_W(ADDR_W), .GPIO_N(GPIO_N)) i_boot_image_loader (.*);
  boot_media_model i_boot_media_model (.clk_i(clk_i), .flash_sclk_i(flash_sclk_o),
    .flash_cs_n_i(flash_cs_n_o), .flash_mosi_i(flash_mosi_o), .flash_miso_o(flash_miso_i),
    .otp_rd_i(otp_rd_o), .otp_addr_i(otp_addr_o), .otp_data_o(otp_data_i),
    .otp_valid_o(otp_valid_i), .otp_lat_i(otp_lat));

  always #20 clk_i = ~clk_i;
  // Outputs are collected mid-cycle, where they have settled after the launching edge.
  always @(negedge clk_i) begin
    if (ram_we_o === 1'b1) begin
      wa.push_back(32'(ram_addr_o));
      wd.push_back(ram_wdata_o);
    end
    if (flash_cs_n_o === 1'b0) cs_seen = 1'b1;
  end

  task automatic close_out();
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 32; i++) r = (r[0] ^ d[i]) ? ((r >> 1) ^ boot_loader_pkg::CRC_POLY) : (r >> 1);
    return r;
  endfunction : crc_word

  // Mode 0 is a good checksum, 1 the skip word, 2 a checksum with one bit wrong.
  task automatic boot(input bit otp, input int n, input int mode);
    logic [31:0] crc;
    logic [31:0] w [0:5];
    int          cnt;
    w[0] = 32'(n);
    crc = crc_word(boot_loader_pkg::CRC_INIT, w[0]);
    for (int k = 1; k <= n; k++) begin
      w[k] = 32'h6C3A5E00 | 32'(k);
      crc = crc_word(crc, w[k]);
    end
    w[n + 1] = (mode == 1) ? boot_loader_pkg::CRC_SKIP : ~crc ^ 32'(mode == 2);
    for (int j = 0; j <= n + 1; j++) begin
      i_boot_media_model.omem[j] = w[j];
      for (int b = 0; b < 4; b++) i_boot_media_model.fmem[4 * j + b] = w[j][8 * b +: 8];
    end
    i_boot_media_model.omem[11'h7FF] = otp ? 32'hFFFFFFFF : 32'hFFFFFFDF;
    rst_n_i = 1'b0;
    repeat (6) @(negedge clk_i);
    check("pulldown held", 32'(gpio_pulldown_o), 32'hFFFFFFFF);
    check("core reset held", 32'(core_reset_o), 32'h1);
    wa.delete();
    wd.delete();
    cs_seen = 1'b0;
    rst_n_i = 1'b1;
    cnt = 0;
    while (otp_rd_o !== 1'b1) begin
      @(negedge clk_i);
      cnt++;
      if (cnt > 4000) begin
        n_errors++;
        close_out();
      end
    end
    check("first read row", 32'(otp_addr_o), 32'(boot_loader_pkg::OTP_SEC_ADDR));
    check("boot delay", 32'(cnt >= boot_loader_pkg::INTRST_CYCLES && cnt <= 32'hEA6), 32'h1);
    check("pulldown off", 32'(gpio_pulldown_o), 32'h0);
    cnt = 0;
    while (boot_done_o !== 1'b1 && boot_error_o !== 1'b1) begin
      @(negedge clk_i);
      cnt++;
      if (cnt > 8000) begin
        n_errors++;
        close_out();
      end
    end
    repeat (2) @(negedge clk_i);
    check("done", 32'(boot_done_o), 32'(mode != 2));
    check("error", 32'(boot_error_o), 32'(mode == 2));
    check("core reset", 32'(core_reset_o), 32'(mode == 2));
    check("start address", start_addr_o, boot_loader_pkg::RAM_BASE);
    check("flash used", 32'(cs_seen), 32'(!otp));
    if (!otp) check("flash header", i_boot_media_model.hdr, boot_loader_pkg::FLASH_READ_SEQ);
    check("word count", 32'(wa.size()), 32'(n));
    for (int k = 0; k < wa.size(); k++) begin
      check("ram address", wa[k], 32'(k));
      check("ram data", wd[k], w[k + 1]);
    end
  endtask : boot

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_flash_good();
    otp_lat = 4'h1;
    boot(1'b0, 3, 0);
  endtask : t_flash_good

  task automatic t_flash_skip();
    boot(1'b0, 1, 1);
  endtask : t_flash_skip

  task automatic t_flash_bad();
    boot(1'b0, 2, 2);
  endtask : t_flash_bad

  task automatic t_empty_image();
    boot(1'b0, 0, 0);
  endtask : t_empty_image

  task automatic t_otp_slow();
    otp_lat = 4'h6;
    boot(1'b1, 2, 0);
  endtask : t_otp_slow

  initial begin
    clk_i = 1'b0;
    reset_i = 1'b1;
    rst_n_i = 1'b0;
    otp_lat = 4'h1;
    n_errors = 0;
    n_compared = 0;
    cs_seen = 1'b0;
    repeat (20) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (25000) @(negedge clk_i);
    t_flash_good();
    t_flash_skip();
    t_flash_bad();
    t_empty_image();
    t_otp_slow();
    close_out();
  end
endmodule : test_boot_image_loader

bind boot_image_loader boot_image_loader_monitor #(.ADDR_W(ADDR_W), .GPIO_N(GPIO_N))
  i_boot_image_loader_monitor (.*);
